/* hw/ccr_top.sv */
`default_nettype none

// How it works
// R1: Core runs n times the board clock rate, n being 2, 3 or 4.
// R2: Ratio straps are taken once after reset and then held fixed.
// R3: External port advances on a board-rate enable regardless of n.
// R4: Board keeps its clock running, steady, never below minimum frequency.
// R5: Clock copy output toggles at board clock rate while enabled.
// R6: Clock output disable bit releases the clock copy pin.
// R7: Keeper holds last clock level, enabled only for identity 00x.
// R8: Multiprocessor systems clock other logic from the shared board clock.
// R9: Reset gives known state; fetch then starts at the reset vector.
// R10: System holds the active-low reset asserted while power comes up.
// R11: Boot memory select pin direction follows memory and link boot selects.
// R12: Board ties the boot select pins to fixed levels.
// R13: Boot mode decoded from memory-boot, link-boot and select pin levels.
module ccr_top
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Static straps
	input  wire logic [3:0]  core_ratio_select,
	input  wire logic [2:0]  processor_identity_inputs,
	input  wire logic        memory_boot_select,
	input  wire logic        link_boot_select,
	// Configuration bit
	input  wire logic        clock_output_disable,
	// Boot memory select pin
	input  wire logic        boot_memory_select_i,
	output logic             boot_memory_select_o,
	output logic             boot_memory_select_oe,
	input  wire logic        boot_read_active,
	// Clock copy pin
	output logic             clock_copy_output_o,
	output logic             clock_copy_output_oe,
	output logic             clock_copy_keeper_en,
	// Rates
	output logic             core_tick,
	output logic             port_tick,
	output logic [2:0]       core_ratio,
	// Instruction fetch
	output logic [31:0]      fetch_addr,
	output logic             fetch_valid,
	input  wire logic        fetch_ready,
	// Boot status
	output logic [4:0]       boot_mode
);

	ccr_div_if dv ();

	ccr_state_e  state_q;
	logic [2:0]  ratio_q;
	ccr_boot_e   boot_q;
	logic [31:0] addr_q;
	logic        valid_q;
	logic        bms_o_q;
	logic        keep_level_q;

	// Strap code to core multiple; unlisted codes fall back to the slowest
	function automatic logic [2:0] ratio_decode(input logic [3:0] code);
		unique case (code)
			RATIO_CODE_X3: ratio_decode = RATIO_X3;
			RATIO_CODE_X4: ratio_decode = RATIO_X4;
			default:       ratio_decode = RATIO_X2;
		endcase
	endfunction

	// Only memory boot with link boot low drives the select pin
	function automatic logic bms_drives(input logic eb, input logic lb);
		bms_drives = eb && !lb;
	endfunction

	// Boot mode from the three pin levels
	function automatic ccr_boot_e boot_decode(input logic eb, input logic lb, input logic boot_memory_select);
		if (bms_drives(eb, lb)) begin
			boot_decode = BOOT_MEMORY;
		end else if (eb) begin
			boot_decode = BOOT_RESERVED;
		end else if (!lb && boot_memory_select) begin
			boot_decode = BOOT_HOST;
		end else if (lb && boot_memory_select) begin
			boot_decode = BOOT_LINK;
		end else if (!lb) begin
			boot_decode = BOOT_NONE;
		end else begin
			boot_decode = BOOT_RESERVED;
		end
	endfunction

	// Sequencer: capture straps, load the vector, then run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_CAPTURE;  // R9
		end else begin
			unique case (state_q)
				ST_CAPTURE: state_q <= ST_START;
				ST_START:   state_q <= ST_RUN;
				ST_RUN:     state_q <= ST_RUN;
			endcase
		end
	end

	// Straps sampled once; later changes are ignored so the ratio stays whole
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ratio_q <= RATIO_RESET;
			boot_q  <= BOOT_NONE;
		end else if (state_q == ST_CAPTURE) begin
			ratio_q <= ratio_decode(core_ratio_select);  // R2
			boot_q  <= boot_decode(memory_boot_select, link_boot_select,
				boot_memory_select_i);  // R13
		end
	end

	// Fetch address: vector first, then one step per accepted fetch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q  <= ADDR_RESET;
			valid_q <= 1'b0;
		end else if (state_q == ST_START) begin
			addr_q  <= RESET_VECTOR;  // R9
			valid_q <= 1'b1;
		end else if (valid_q && fetch_ready) begin
			addr_q  <= 32'(addr_q + FETCH_STEP);
		end
	end

	// Boot chip select is active low while the loader reads
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bms_o_q <= 1'b1;
		end else begin
			bms_o_q <= !boot_read_active;
		end
	end

	// Keeper tracks the level last driven onto the clock copy pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			keep_level_q <= 1'b0;
		end else if (!clock_output_disable) begin
			keep_level_q <= dv.level;  // R7
		end
	end

	// Divider runs only once the ratio is fixed
	assign dv.run   = (state_q != ST_CAPTURE);
	assign dv.ratio = ratio_q;  // R1

	ccr_divider u_div (
		.clk    (clk),
		.resetn (resetn),
		.dv     (dv)
	);

	// Core advances every cycle, the port once per board period
	assign core_tick  = (state_q == ST_RUN);  // R1
	assign port_tick  = dv.tick;  // R3
	assign core_ratio = ratio_q;

	// Clock copy pin; when released the keeper alone holds the wire
	assign clock_copy_output_o  = clock_output_disable ? keep_level_q : dv.level;  // R5
	assign clock_copy_output_oe = !clock_output_disable;  // R6
	assign clock_copy_keeper_en =
		(processor_identity_inputs[2:1] == KEEPER_ID_HIGH);  // R7

	// Select pin drives only in memory boot, else it stays an input
	assign boot_memory_select_oe = (boot_q == BOOT_MEMORY);  // R11
	assign boot_memory_select_o  = bms_o_q;

	assign fetch_addr  = addr_q;
	assign fetch_valid = valid_q;
	assign boot_mode   = boot_q;

endmodule

`default_nettype wire

/* hw/ccr_pkg.sv */
`default_nettype none

package ccr_pkg;

	// Core clock period at 25 MHz
	localparam int unsigned CLK_PERIOD_NS = 40;

	// Ratio select strap codes and the multiple each one selects
	localparam logic [3:0] RATIO_CODE_X2 = 4'h0;
	localparam logic [3:0] RATIO_CODE_X3 = 4'h1;
	localparam logic [3:0] RATIO_CODE_X4 = 4'h2;
	localparam logic [2:0] RATIO_X2      = 3'h2;
	localparam logic [2:0] RATIO_X3      = 3'h3;
	localparam logic [2:0] RATIO_X4      = 3'h4;

	// Program memory address taken at the end of reset
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
	localparam logic [31:0] FETCH_STEP   = 32'h0000_0001;

	// Identity bits that must be zero for the keeper to be on
	localparam logic [1:0] KEEPER_ID_HIGH = 2'h0;

	// Reset values
	localparam logic [2:0]  RATIO_RESET = RATIO_X2;
	localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_CAPTURE = 3'b001,
		ST_START   = 3'b010,
		ST_RUN     = 3'b100
	} ccr_state_e;

	// Boot modes, one-hot
	typedef enum logic [4:0] {
		BOOT_NONE     = 5'b00001,
		BOOT_MEMORY   = 5'b00010,
		BOOT_HOST     = 5'b00100,
		BOOT_LINK     = 5'b01000,
		BOOT_RESERVED = 5'b10000
	} ccr_boot_e;

endpackage

`default_nettype wire

/* hw/ccr_div_if.sv */
`default_nettype none

// Divider control and its board-rate outputs
interface ccr_div_if;
	logic       run;
	logic [2:0] ratio;
	logic       tick;
	logic       level;

	modport master (
		output run,
		output ratio,
		input  tick,
		input  level
	);

	modport divider (
		input  run,
		input  ratio,
		output tick,
		output level
	);
endinterface

`default_nettype wire

/* hw/ccr_divider.sv */
`default_nettype none

module ccr_divider
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control and board-rate outputs
	ccr_div_if.divider dv
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [2:0] half;
	logic       tick_q;
	logic       level_q;

	// Next phase count; wraps after ratio core cycles
	always_comb begin
		half = 3'((dv.ratio + 3'h1) >> 1);
		if (!dv.run) begin
			cnt_d = 3'h0;
		end else if (cnt_q == 3'(dv.ratio - 3'h1)) begin
			cnt_d = 3'h0;
		end else begin
			cnt_d = 3'(cnt_q + 3'h1);
		end
	end

	// Phase counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Tick once per board period, level high for the first half
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_q  <= 1'b0;
			level_q <= 1'b0;
		end else begin
			tick_q  <= dv.run && (cnt_d == 3'h0);
			level_q <= dv.run && (cnt_d < half);  // Odd ratio gives a long high phase
		end
	end

	assign dv.tick  = tick_q;
	assign dv.level = level_q;

endmodule

`default_nettype wire

/* verif/ccr_board.sv */
`default_nettype none

// Board oscillator and power-on reset circuitry
module ccr_board (
	output logic     clk,
	output logic     resetn,
	input wire logic rst_req
);
	timeunit 1ns;
	timeprecision 1ns;

	// Oscillator never stops or retimes; all bench logic runs from it
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// Reset is low from power-up and for 16 clocks on each request
	initial resetn = 1'b0;
	always @(posedge clk) begin
		if (rst_req) begin
			resetn = 1'b0;
			repeat (16) @(posedge clk);
			#1 resetn = 1'b1;
		end
	end
endmodule

`default_nettype wire

/* verif/ccr_properties.sv */
`default_nettype none

module ccr_properties
	import ccr_pkg::*;
(
	// Clock, reset and straps
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [2:0]  processor_identity_inputs,
	input wire logic        memory_boot_select,
	input wire logic        link_boot_select,
	input wire logic        clock_output_disable,
	input wire logic        boot_read_active,
	// Outputs watched
	input wire logic        boot_memory_select_o,
	input wire logic        boot_memory_select_oe,
	input wire logic        clock_copy_output_o,
	input wire logic        clock_copy_output_oe,
	input wire logic        clock_copy_keeper_en,
	input wire logic        port_tick,
	input wire logic [2:0]  core_ratio,
	input wire logic [31:0] fetch_addr,
	input wire logic        fetch_valid,
	input wire logic        fetch_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Quiet core cycles before the next board tick, one per ratio
	sequence gap2; !port_tick ##1 port_tick; endsequence
	sequence gap3; !port_tick[*2] ##1 port_tick; endsequence
	sequence gap4; !port_tick[*3] ##1 port_tick; endsequence

	AST_TICK_X2: assert property (port_tick && core_ratio == RATIO_X2 |=> gap2)
		else $error("tick gap x2");
	AST_TICK_X3: assert property (port_tick && core_ratio == RATIO_X3 |=> gap3)
		else $error("tick gap x3");
	AST_TICK_X4: assert property (port_tick && core_ratio == RATIO_X4 |=> gap4)
		else $error("tick gap x4");
	AST_RATIO_HELD: assert property (fetch_valid |=> $stable(core_ratio))
		else $error("ratio moved");
	AST_COPY_HIGH: assert property (port_tick && clock_copy_output_oe |-> clock_copy_output_o)
		else $error("copy low at tick");
	AST_COPY_OE: assert property (clock_copy_output_oe == !clock_output_disable)
		else $error("copy enable wrong");
	AST_KEEPER: assert property (clock_copy_keeper_en ==
		(processor_identity_inputs[2:1] == KEEPER_ID_HIGH)) else $error("keeper wrong");
	AST_VECTOR: assert property ($rose(fetch_valid) |-> fetch_addr == RESET_VECTOR)
		else $error("bad start address");
	AST_FETCH_STEP: assert property (fetch_valid && fetch_ready |=>
		fetch_addr == $past(fetch_addr) + FETCH_STEP) else $error("bad fetch step");
	AST_BMS_DIR: assert property (fetch_valid |->
		boot_memory_select_oe == (memory_boot_select && !link_boot_select))
		else $error("select direction");
	AST_BMS_DRIVE: assert property (boot_memory_select_oe |=>
		boot_memory_select_o == !$past(boot_read_active)) else $error("select drive");
endmodule

bind ccr_top ccr_properties u_props (.*);

`default_nettype wire

/* verif/tb_top.sv */
`default_nettype none

module tb_top
	import ccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Board side, straps and observed outputs
	logic        clk, resetn, rst_req, memory_boot_select, link_boot_select;
	logic        clock_output_disable, boot_memory_select_i, boot_read_active, fetch_ready;
	logic [3:0]  core_ratio_select;
	logic [2:0]  processor_identity_inputs, core_ratio;
	logic        boot_memory_select_o, boot_memory_select_oe, clock_copy_output_o, core_tick;
	logic        clock_copy_output_oe, clock_copy_keeper_en, port_tick, fetch_valid;
	logic [31:0] fetch_addr, ticks, highs;
	logic [4:0]  boot_mode;
	int          fails = 0, samples_checked = 0;
	logic [3:0]  codes [4] = '{RATIO_CODE_X2, RATIO_CODE_X3, RATIO_CODE_X4, 4'hF};
	logic [2:0]  mults [4] = '{RATIO_X2, RATIO_X3, RATIO_X4, RATIO_X2};
	logic [2:0]  straps [6] = '{3'h4, 3'h1, 3'h3, 3'h0, 3'h2, 3'h7};
	ccr_boot_e   modes [6] = '{BOOT_MEMORY, BOOT_HOST, BOOT_LINK, BOOT_NONE,
		BOOT_RESERVED, BOOT_RESERVED};

	ccr_board brd (.clk, .resetn, .rst_req);
	ccr_top dut (.*);

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// This task moves straps only while reset is held, so capture sees them settled
	task automatic boot(logic [3:0] rs, logic [2:0] bs);
		rst_req = 1'b1;
		@(posedge clk);
		#1 rst_req = 1'b0;
		core_ratio_select = rs;
		{memory_boot_select, link_boot_select, boot_memory_select_i} = bs;
		repeat (19) @(posedge clk);
		#1;
	endtask

	initial begin
		{rst_req, clock_output_disable, boot_read_active, fetch_ready} = 4'h0;
		{memory_boot_select, link_boot_select, boot_memory_select_i} = 3'h1;
		core_ratio_select = 4'h0;
		processor_identity_inputs = 3'h0;
		// Every ratio code; 12 cycles hold a whole number of board periods
		for (int i = 0; i < 4; i++) begin
			boot(codes[i], 3'h1);
			check("core_ratio", core_ratio, mults[i]);
			ticks = 0;
			highs = 0;
			repeat (12) begin
				@(posedge clk);
				#1 ticks += port_tick;
				highs += clock_copy_output_o;
			end
			check("tick_count", ticks, 12 / mults[i]);
			check("copy_high", highs, 12 / mults[i] * ((mults[i] + 1) / 2));
			core_ratio_select = codes[(i + 1) % 4];
			repeat (3) @(posedge clk);
			#1 check("ratio_held", core_ratio, mults[i]);
		end
		check("fetch_addr", fetch_addr, RESET_VECTOR);
		check("fetch_valid", fetch_valid, 1'b1);
		fetch_ready = 1'b1;
		repeat (3) @(posedge clk);
		#1 fetch_ready = 1'b0;
		check("fetch_next", fetch_addr, RESET_VECTOR + 3 * FETCH_STEP);
		check("core_tick", core_tick, 1'b1);
		// Disable bit and all identity values
		for (int i = 0; i < 8; i++) begin
			processor_identity_inputs = 3'(i);
			clock_output_disable = i[0];
			@(posedge clk);
			#1 check("copy_oe", clock_copy_output_oe, !i[0]);
			check("keeper", clock_copy_keeper_en, i < 2);
		end
		// Six of the eight boot strap combinations
		for (int i = 0; i < 6; i++) begin
			boot(4'h0, straps[i]);
			check("boot_mode", boot_mode, modes[i]);
			check("bms_oe", boot_memory_select_oe, i == 0);
			boot_read_active = 1'b1;
			@(posedge clk);
			#1 boot_read_active = 1'b0;
			if (i == 0) check("bms_drive", boot_memory_select_o, 1'b0);
			@(posedge clk);
			#1 check("bms_idle", boot_memory_select_o, 1'b1);
		end
		stop_test();
	end

	// Whole run needs about 280 clocks
	initial begin
		#200000;
		fails++;
		stop_test();
	end
endmodule

`default_nettype wire
